// ==== pwrseq_top.sv ====
// Power sequencing, reset and sleep-state pin logic of the standby-powered controller.
// Behaviour
// - Main power-good rises 400 ms after main supply detected good.
// - Resume-reset releases 66 ms after standby supply good at low threshold.
// - Deep-standby power-good asserts 66 ms after standby good at high threshold.
// - Reset button is debounced; a new level needs 50 ms of stability.
// - Both platform resets follow host bus reset, each software-forcible into reset.
// - Memory rail switch low working, high suspend-to-RAM, soft-off low unless programmed.
// - In soft-off both standby rail controls default to 1, cutting standby rail.
// - Keyboard CPU reset and address-20 gate are high after system reset.
// - Deep-sleep acknowledge asserts only after warn has been seen asserted.
// - Second warn/acknowledge pair works only when configuration bit 7 is set; the block takes this enable from control bit 8.
// - Power request output is active low and issued as a pulse.
// - Supply-on control switches external supply via its on-request line.
// - Power-good style strap sampled at power on; 0 selects second-vendor behaviour.
// - Core regulator and link rail enables are active high.
// - Standby and main LEDs blink at selectable rate when enabled.
// - Case intrusion is captured in a latch kept across main power loss.
// - Wake event output asks the system to resume from suspend-to-RAM.
module pwrseq_top #(
	parameter int unsigned MAIN_PG_CYC = pwrseq_pkg::MAIN_PG_CYC,
	parameter int unsigned RESUME_CYC = pwrseq_pkg::RESUME_CYC,
	parameter int unsigned DEEP_PG_CYC = pwrseq_pkg::DEEP_PG_CYC,
	parameter int unsigned DEBOUNCE_CYC = pwrseq_pkg::DEBOUNCE_CYC,
	parameter int unsigned REQ_PULSE_CYC = pwrseq_pkg::REQ_PULSE_CYC,
	parameter int unsigned LED_DIV = 1
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic srst_i,
	// Supply detectors and strap.
	input wire logic main_supply_good_i,
	input wire logic standby_good_low_i,
	input wire logic standby_good_high_i,
	input wire logic power_good_style_strap_i,
	// Host reset and sleep-state inputs, active low.
	input wire logic host_bus_reset_n_i,
	input wire logic suspend_ram_in_n_i,
	input wire logic soft_off_in_n_i,
	// Buttons and case switch, active low.
	input wire logic reset_button_in_n_i,
	input wire logic power_button_in_n_i,
	input wire logic case_intrusion_in_n_i,
	// Deep-sleep handshake, active low.
	input wire logic deep_sleep_warn_a_n_i,
	input wire logic deep_sleep_warn_b_n_i,
	output logic deep_sleep_ack_a_n_o,
	output logic deep_sleep_ack_b_n_o,
	// Power-good and reset outputs.
	output logic main_power_good_o,
	output logic standby_resume_reset_n_o,
	output logic deep_standby_power_good_o,
	output logic platform_reset_out_a_n_o,
	output logic platform_reset_out_b_n_o,
	output logic reset_button_o,
	// Rail and supply controls.
	output logic memory_rail_switch_o,
	output logic standby_rail_ctrl_0_n_o,
	output logic standby_rail_ctrl_1_n_o,
	output logic supply_on_ctrl_n_o,
	output logic power_request_pulse_n_o,
	output logic core_reg_on_o,
	output logic link_rail_on_o,
	// Keyboard-side outputs and their request inputs.
	output logic keyboard_cpu_reset_n_o,
	output logic address_line_20_gate_o,
	input wire logic kbd_cpu_reset_req_i,
	input wire logic kbd_gate_low_req_i,
	// LEDs and wake.
	output logic standby_led_o,
	output logic main_led_o,
	output logic wake_event_n_o,
	// Register port.
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [15:0] reg_rdata_o
);
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h1;

	pwrseq_pkg::sw_ctrl_t ctrl_q;
	pwrseq_pkg::sw_stat_t stat;
	pwrseq_pkg::pstate_t pstate;
	logic main_pg_raw, deep_pg_raw, resume_ok, button_lvl;
	logic pwr_btn_q, strap_q, strap_done_q, case_q;
	logic warn_a_seen_q, warn_b_seen_q;
	logic [$clog2(REQ_PULSE_CYC + 1)-1:0] req_cnt_q;
	logic [31:0] led_cnt_sb_q, led_cnt_main_q;
	logic led_sb_q, led_main_q;

	// Half period of the LED blink for a rate select, scaled for simulation.
	function automatic logic [31:0] led_half(input logic [1:0] rate);
		unique case (rate)
			2'd0: led_half = 32'(pwrseq_pkg::LED_HALF_0 / LED_DIV);
			2'd1: led_half = 32'(pwrseq_pkg::LED_HALF_1 / LED_DIV);
			2'd2: led_half = 32'(pwrseq_pkg::LED_HALF_2 / LED_DIV);
			default: led_half = 32'(pwrseq_pkg::LED_HALF_3 / LED_DIV);
		endcase
	endfunction

	// Delayed power-good generators and the reset button filter.
	pg_delay #(.COUNT(MAIN_PG_CYC)) u_main_pg (
		.clk_i(clk_i), .srst_i(srst_i), .good_i(main_supply_good_i), .good_o(main_pg_raw));
	pg_delay #(.COUNT(RESUME_CYC)) u_resume (
		.clk_i(clk_i), .srst_i(srst_i), .good_i(standby_good_low_i), .good_o(resume_ok));
	pg_delay #(.COUNT(DEEP_PG_CYC)) u_deep_pg (
		.clk_i(clk_i), .srst_i(srst_i), .good_i(standby_good_high_i), .good_o(deep_pg_raw));
	debounce #(.COUNT(DEBOUNCE_CYC), .INIT(1'b1)) u_rst_btn (
		.clk_i(clk_i), .srst_i(srst_i), .raw_i(reset_button_in_n_i), .level_o(button_lvl));

	// Power state from the sleep inputs; soft-off takes precedence.
	always_comb begin
		if (!soft_off_in_n_i) begin
			pstate = pwrseq_pkg::PST_OFF;
		end else if (!suspend_ram_in_n_i) begin
			pstate = pwrseq_pkg::PST_RAM;
		end else begin
			pstate = pwrseq_pkg::PST_WORK;
		end
	end

	// Strap is caught once after reset release so a later change is ignored.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			strap_q <= 1'b1;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_q <= power_good_style_strap_i;
			strap_done_q <= 1'b1;
		end
	end

	// Power-good style: second-vendor style also gates on the resume reset being released.
	assign main_power_good_o = strap_q ? main_pg_raw : (main_pg_raw && resume_ok);
	assign standby_resume_reset_n_o = resume_ok;
	assign deep_standby_power_good_o = deep_pg_raw;
	assign reset_button_o = !button_lvl;

	// Platform resets follow the host bus reset or a software force, and the button.
	assign platform_reset_out_a_n_o = host_bus_reset_n_i && !ctrl_q.force_rst_a && button_lvl;
	assign platform_reset_out_b_n_o = host_bus_reset_n_i && !ctrl_q.force_rst_b && button_lvl;

	// Rails per power state.
	always_comb begin
		memory_rail_switch_o = 1'b0;
		standby_rail_ctrl_0_n_o = 1'b0;
		standby_rail_ctrl_1_n_o = 1'b0;
		unique case (pstate)
			pwrseq_pkg::PST_WORK: memory_rail_switch_o = 1'b0;
			pwrseq_pkg::PST_RAM: memory_rail_switch_o = 1'b1;
			pwrseq_pkg::PST_OFF: begin
				memory_rail_switch_o = ctrl_q.mem_high_in_off;
				standby_rail_ctrl_0_n_o = !ctrl_q.erp_on_in_off;
				standby_rail_ctrl_1_n_o = !ctrl_q.erp_on_in_off;
			end
			default: memory_rail_switch_o = 1'b0;
		endcase
	end

	// Supply on request is low (on) only in the working state; regulators follow main power.
	assign supply_on_ctrl_n_o = (pstate != pwrseq_pkg::PST_WORK);
	assign core_reg_on_o = main_pg_raw;
	assign link_rail_on_o = main_pg_raw;

	// Keyboard lines rest high after reset and drop only on a request.
	assign keyboard_cpu_reset_n_o = !kbd_cpu_reset_req_i;
	assign address_line_20_gate_o = !kbd_gate_low_req_i;

	// A power button press starts a fixed-length low pulse; holding the button does not extend it.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pwr_btn_q <= 1'b1;
			req_cnt_q <= '0;
		end else begin
			pwr_btn_q <= power_button_in_n_i;
			if (pwr_btn_q && !power_button_in_n_i && req_cnt_q == '0) begin
				req_cnt_q <= ($bits(req_cnt_q))'(REQ_PULSE_CYC);
			end else if (req_cnt_q != '0) begin
				req_cnt_q <= req_cnt_q - ($bits(req_cnt_q))'(1);
			end
		end
	end
	assign power_request_pulse_n_o = (req_cnt_q == '0);

	// Acknowledge only once the warn was seen; warn release withdraws it.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			warn_a_seen_q <= 1'b0;
			warn_b_seen_q <= 1'b0;
		end else begin
			warn_a_seen_q <= !deep_sleep_warn_a_n_i;
			warn_b_seen_q <= !deep_sleep_warn_b_n_i && ctrl_q.dsw_b_en;
		end
	end
	assign deep_sleep_ack_a_n_o = !(warn_a_seen_q && !deep_sleep_warn_a_n_i);
	assign deep_sleep_ack_b_n_o = !(warn_b_seen_q && !deep_sleep_warn_b_n_i && ctrl_q.dsw_b_en);

	// Case intrusion latch; a new event wins over a software clear.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			case_q <= 1'b0;
		end else if (!case_intrusion_in_n_i) begin
			case_q <= 1'b1;
		end else if (reg_we_i && reg_addr_i == REG_CTRL && reg_wdata_i[pwrseq_pkg::CFG_CASE_CLEAR_BIT]) begin
			case_q <= 1'b0;
		end
	end

	// Wake request is held while in suspend-to-RAM and software asks for it.
	assign wake_event_n_o = !(ctrl_q.wake_req && pstate == pwrseq_pkg::PST_RAM);

	// Standby LED blinker.
	always_ff @(posedge clk_i) begin
		if (srst_i || !ctrl_q.led_sb_en) begin
			led_cnt_sb_q <= '0;
			led_sb_q <= 1'b0;
		end else if (led_cnt_sb_q >= led_half(ctrl_q.led_sb_rate) - 32'd1) begin
			led_cnt_sb_q <= '0;
			led_sb_q <= !led_sb_q;
		end else begin
			led_cnt_sb_q <= led_cnt_sb_q + 32'd1;
		end
	end

	// Main LED blinker.
	always_ff @(posedge clk_i) begin
		if (srst_i || !ctrl_q.led_main_en) begin
			led_cnt_main_q <= '0;
			led_main_q <= 1'b0;
		end else if (led_cnt_main_q >= led_half(ctrl_q.led_main_rate) - 32'd1) begin
			led_cnt_main_q <= '0;
			led_main_q <= !led_main_q;
		end else begin
			led_cnt_main_q <= led_cnt_main_q + 32'd1;
		end
	end
	// A disabled LED shows steady on when its supply is up.
	assign standby_led_o = ctrl_q.led_sb_en ? led_sb_q : standby_good_low_i;
	assign main_led_o = ctrl_q.led_main_en ? led_main_q : main_pg_raw;

	// Control register write; the clear bit is a pulse and is not stored.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_q <= '0;
		end else if (reg_we_i && reg_addr_i == REG_CTRL) begin
			ctrl_q <= pwrseq_pkg::sw_ctrl_t'(reg_wdata_i[12:0]);
			ctrl_q.case_clear <= 1'b0;
		end
	end

	// Status and read data, one cycle after the read strobe.
	assign stat = '{case_open: case_q, vendor_b_style: !strap_q, reset_button: !button_lvl,
		main_pg: main_power_good_o, deep_pg: deep_pg_raw, pstate: pstate};
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_re_i) begin
			unique case (reg_addr_i)
				REG_CTRL: reg_rdata_o <= {3'd0, ctrl_q};
				REG_STAT: reg_rdata_o <= {9'd0, stat};
				default: reg_rdata_o <= '0;
			endcase
		end
	end
endmodule

// ==== pwrseq_pkg.sv ====
// Package with constants and carrier types for the power sequencing pin block.
package pwrseq_pkg;

	// Clock rate and timing figures.
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MAIN_PG_DELAY_MS = 400;
	localparam int unsigned RESUME_DELAY_MS = 66;
	localparam int unsigned DEEP_PG_DELAY_MS = 66;
	localparam int unsigned DEBOUNCE_MS = 50;
	localparam int unsigned REQ_PULSE_MS = 1;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned MAIN_PG_CYC = MAIN_PG_DELAY_MS * CYC_PER_MS;
	localparam int unsigned RESUME_CYC = RESUME_DELAY_MS * CYC_PER_MS;
	localparam int unsigned DEEP_PG_CYC = DEEP_PG_DELAY_MS * CYC_PER_MS;
	localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
	localparam int unsigned REQ_PULSE_CYC = REQ_PULSE_MS * CYC_PER_MS;

	// Configuration field positions (index 2Ch bit 7 enables the second pair).
	localparam int unsigned CFG_DSW_B_BIT = 7;
	// Write-one pulse that clears the case latch; it sits at the case_clear field of the control word.
	localparam int unsigned CFG_CASE_CLEAR_BIT = 1;

	// LED blink rate selects: half periods in cycles.
	localparam int unsigned LED_HALF_0 = CLK_HZ / 2;
	localparam int unsigned LED_HALF_1 = CLK_HZ / 4;
	localparam int unsigned LED_HALF_2 = CLK_HZ / 8;
	localparam int unsigned LED_HALF_3 = CLK_HZ / 16;

	// Power states decoded from the sleep inputs.
	typedef enum logic [1:0] {
		PST_WORK,
		PST_RAM,
		PST_OFF
	} pstate_t;

	// Software controls, grouped.
	typedef struct packed {
		logic force_rst_a;
		logic force_rst_b;
		logic mem_high_in_off;
		logic erp_on_in_off;
		logic dsw_b_en;
		logic led_sb_en;
		logic led_main_en;
		logic [1:0] led_sb_rate;
		logic [1:0] led_main_rate;
		logic case_clear;
		logic wake_req;
	} sw_ctrl_t;

	// Status seen by software.
	typedef struct packed {
		logic case_open;
		logic vendor_b_style;
		logic reset_button;
		logic main_pg;
		logic deep_pg;
		pstate_t pstate;
	} sw_stat_t;

endpackage

// ==== pg_delay.sv ====
// Delayed power-good generator: output rises after input good for a full count.
module pg_delay #(
	parameter int unsigned COUNT = 100
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic srst_i,
	// Supply condition and delayed result.
	input wire logic good_i,
	output logic good_o
);
	localparam int unsigned W = $clog2(COUNT + 1);
	logic [W-1:0] cnt_q;

	// Count while good; any drop restarts the count and drops the output.
	always_ff @(posedge clk_i) begin
		if (srst_i || !good_i) begin
			cnt_q <= '0;
			good_o <= 1'b0;
		end else if (cnt_q == W'(COUNT - 1)) begin
			good_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + W'(1);
		end
	end
endmodule

// ==== debounce.sv ====
// Input debouncer: accepts a new level only after it stays stable for COUNT cycles.
module debounce #(
	parameter int unsigned COUNT = 100,
	parameter logic INIT = 1'b1
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic srst_i,
	// Raw and filtered level.
	input wire logic raw_i,
	output logic level_o
);
	localparam int unsigned W = $clog2(COUNT + 1);
	logic [W-1:0] cnt_q;

	// A differing raw level must persist; any bounce restarts the count.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt_q <= '0;
			level_o <= INIT;
		end else if (raw_i == level_o) begin
			cnt_q <= '0;
		end else if (cnt_q == W'(COUNT - 1)) begin
			level_o <= raw_i;
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + W'(1);
		end
	end
endmodule

// ==== pwrseq_properties.sv ====
// Checker with the timing relations of the power sequencing pins.
module pwrseq_checker #(
	parameter int unsigned MAIN_PG_CYC = 1,
	parameter int unsigned RESUME_CYC = 1,
	parameter int unsigned DEEP_PG_CYC = 1,
	parameter int unsigned DEBOUNCE_CYC = 1,
	parameter int unsigned REQ_PULSE_CYC = 1
) (
	// Clock, reset and inputs.
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic main_supply_good_i,
	input wire logic standby_good_low_i,
	input wire logic standby_good_high_i,
	input wire logic host_bus_reset_n_i,
	input wire logic suspend_ram_in_n_i,
	input wire logic soft_off_in_n_i,
	input wire logic reset_button_in_n_i,
	input wire logic power_button_in_n_i,
	input wire logic deep_sleep_warn_a_n_i,
	input wire logic kbd_cpu_reset_req_i,
	// Outputs watched.
	input wire logic deep_sleep_ack_a_n_o,
	input wire logic main_power_good_o,
	input wire logic standby_resume_reset_n_o,
	input wire logic deep_standby_power_good_o,
	input wire logic platform_reset_out_a_n_o,
	input wire logic platform_reset_out_b_n_o,
	input wire logic reset_button_o,
	input wire logic memory_rail_switch_o,
	input wire logic power_request_pulse_n_o,
	input wire logic keyboard_cpu_reset_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned main_q, low_q, high_q, btn_q, pls_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// Run lengths of each qualifying level; a drop starts the run again, as the design's counters must.
	always_ff @(posedge clk_i) begin
		main_q <= (srst_i || !main_supply_good_i) ? 0 : main_q + 1;
		low_q <= (srst_i || !standby_good_low_i) ? 0 : low_q + 1;
		high_q <= (srst_i || !standby_good_high_i) ? 0 : high_q + 1;
		btn_q <= (srst_i || reset_button_in_n_i) ? 0 : btn_q + 1;
		pls_q <= (srst_i || power_request_pulse_n_o) ? 0 : pls_q + 1;
	end
	main_delay_a: assert property ($rose(main_power_good_o) |-> main_q >= MAIN_PG_CYC)
		else $error("main power good rose early");
	main_drop_a: assert property (!main_supply_good_i |=> !main_power_good_o)
		else $error("main power good held after supply loss");
	resume_delay_a: assert property ($rose(standby_resume_reset_n_o) |-> low_q >= RESUME_CYC)
		else $error("resume reset released early");
	deep_late_a: assert property (high_q >= DEEP_PG_CYC + 3 |-> deep_standby_power_good_o)
		else $error("deep standby power good late");
	debounce_min_a: assert property ($rose(reset_button_o) |-> btn_q >= DEBOUNCE_CYC)
		else $error("reset button accepted too soon");
	bus_reset_a: assert property (!host_bus_reset_n_i |-> !platform_reset_out_a_n_o && !platform_reset_out_b_n_o)
		else $error("platform reset not following host reset");
	mem_rail_a: assert property (soft_off_in_n_i && $past(soft_off_in_n_i) && $stable(suspend_ram_in_n_i)
		|-> memory_rail_switch_o == !suspend_ram_in_n_i) else $error("memory rail switch wrong");
	kbd_high_a: assert property (!kbd_cpu_reset_req_i [*2] |-> keyboard_cpu_reset_n_o)
		else $error("keyboard reset low without request");
	ack_after_warn_a: assert property (!deep_sleep_ack_a_n_o |-> !deep_sleep_warn_a_n_i && !$past(deep_sleep_warn_a_n_i))
		else $error("acknowledge without warn");
	pulse_start_a: assert property ($fell(power_button_in_n_i) && power_request_pulse_n_o |=> !power_request_pulse_n_o)
		else $error("request pulse not started");
	pulse_len_a: assert property ($rose(power_request_pulse_n_o) |-> pls_q == REQ_PULSE_CYC)
		else $error("request pulse length wrong");
	cover property ($rose(standby_resume_reset_n_o));
	cover property ($rose(power_request_pulse_n_o));
	cover property (!deep_sleep_ack_a_n_o);
endmodule

bind pwrseq_top pwrseq_checker #(.MAIN_PG_CYC(MAIN_PG_CYC), .RESUME_CYC(RESUME_CYC), .DEEP_PG_CYC(DEEP_PG_CYC),
	.DEBOUNCE_CYC(DEBOUNCE_CYC), .REQ_PULSE_CYC(REQ_PULSE_CYC)) i_pwrseq_checker (.*);

// ==== pwrseq_hub.sv ====
// Model of the platform hub and the supply that face the sequencing pins.
module pwrseq_hub #(
	parameter int unsigned RAMP = 8
) (
	// Clock and bench commands.
	input wire logic clk_i,
	input wire logic sleep_a_i,
	input wire logic sleep_b_i,
	// Pins facing the block.
	input wire logic supply_on_ctrl_n_i,
	output logic main_supply_good_o,
	output logic deep_sleep_warn_a_n_o,
	output logic deep_sleep_warn_b_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned on_q = 0;
	initial {main_supply_good_o, deep_sleep_warn_a_n_o, deep_sleep_warn_b_n_o} = 3'b011;
	// The supply ramps for a while after the on request but loses good at once when turned off.
	always @(posedge clk_i) begin
		on_q <= supply_on_ctrl_n_i ? 0 : on_q + 1;
		main_supply_good_o <= !supply_on_ctrl_n_i && on_q >= RAMP;
		deep_sleep_warn_a_n_o <= !sleep_a_i;
		deep_sleep_warn_b_n_o <= !sleep_b_i;
	end
endmodule

// ==== pwrseq_top_bench.sv ====
// Self-checking bench of the power sequencing block with its hub model.
module pwrseq_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MPG = 40, RES = 20, DPG = 24, DEB = 16, REQ = 10;
	logic clk_i = 0, srst_i = 1, standby_good_low_i = 0, standby_good_high_i = 0, power_good_style_strap_i = 1;
	logic host_bus_reset_n_i = 1, suspend_ram_in_n_i = 1, soft_off_in_n_i = 1, reset_button_in_n_i = 1;
	logic power_button_in_n_i = 1, case_intrusion_in_n_i = 1, kbd_cpu_reset_req_i = 0, kbd_gate_low_req_i = 0;
	logic reg_we_i = 0, reg_re_i = 0, sl_a = 0, sl_b = 0;
	logic [3:0] reg_addr_i = 0;
	logic [15:0] reg_wdata_i = 0, reg_rdata_o;
	logic main_supply_good_i, deep_sleep_warn_a_n_i, deep_sleep_warn_b_n_i, deep_sleep_ack_a_n_o, deep_sleep_ack_b_n_o;
	logic main_power_good_o, standby_resume_reset_n_o, deep_standby_power_good_o, platform_reset_out_a_n_o;
	logic platform_reset_out_b_n_o, reset_button_o, memory_rail_switch_o, standby_rail_ctrl_0_n_o;
	logic standby_rail_ctrl_1_n_o, supply_on_ctrl_n_o, power_request_pulse_n_o, core_reg_on_o, link_rail_on_o;
	logic keyboard_cpu_reset_n_o, address_line_20_gate_o, standby_led_o, main_led_o, wake_event_n_o;
	int bad_count = 0, tests_run = 0, n;
	wire [2:0] pg = {main_power_good_o, standby_resume_reset_n_o, deep_standby_power_good_o};

	pwrseq_top #(.MAIN_PG_CYC(MPG), .RESUME_CYC(RES), .DEEP_PG_CYC(DPG), .DEBOUNCE_CYC(DEB), .REQ_PULSE_CYC(REQ),
		.LED_DIV(1000000)) i_pwrseq_top (.*);
	pwrseq_hub i_pwrseq_hub (.clk_i, .sleep_a_i(sl_a), .sleep_b_i(sl_b), .supply_on_ctrl_n_i(supply_on_ctrl_n_o),
		.main_supply_good_o(main_supply_good_i), .deep_sleep_warn_a_n_o(deep_sleep_warn_a_n_i),
		.deep_sleep_warn_b_n_o(deep_sleep_warn_b_n_i));

	always #5 clk_i = !clk_i;

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1;
		cyc(1);
		reg_we_i <= 0;
	endtask

	// Read data is looked at after the edge that follows the strobe edge; the strobe is low by then, so the value holds.
	task automatic rdchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e, input string what);
		reg_addr_i <= a;
		reg_re_i <= 1;
		cyc(1);
		reg_re_i <= 0;
		cyc(1);
		chk(what, e, reg_rdata_o & m);
	endtask

	// Counts cycles until an output rises; the bound keeps a stuck output from hanging the run.
	task automatic rise(input int k, input int c, input int w, input string what);
		int m;
		m = 0;
		while (pg[k] !== 1'b1 && m < 2000) begin
			cyc(1);
			m++;
		end
		chk(what, 1, 16'(m >= c && m <= c + w));
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Watchdog sized well above the few hundred cycles the sequence needs.
	initial begin
		#300us;
		bad_count++;
		complete_run();
	end

	initial begin
		n = $urandom(32'hd67c_e1eb);
		cyc(2);
		srst_i <= 0;
		standby_good_low_i <= 1;
		standby_good_high_i <= 1;
		cyc(1);
		chk("reset pins", 16'h0003, 16'({pg, keyboard_cpu_reset_n_o, address_line_20_gate_o}));
		fork
			rise(2, MPG, 16, "main delay");
			rise(0, DPG, 3, "deep delay");
			begin
				cyc(RES - 4);
				standby_good_low_i <= 0;
				cyc(1);
				standby_good_low_i <= 1;
				rise(1, RES, 3, "resume delay");
			end
		join
		rdchk(1, 16'h007F, 16'h000C, "status");
		chk("regulators", 16'h0003, 16'({core_reg_on_o, link_rail_on_o}));
		wr(4'h7, 16'hFFFF);
		rdchk(4'h7, 16'hFFFF, 16'h0000, "unmapped");
		for (int i = 0; i < 4; i++) begin
			wr(0, 16'(i) << 11);
			cyc(2);
			chk("forced resets", 16'({i[1] == 0, i[0] == 0}), 16'({platform_reset_out_a_n_o, platform_reset_out_b_n_o}));
		end
		host_bus_reset_n_i <= 0;
		cyc(2);
		chk("bus reset", 0, 16'({platform_reset_out_a_n_o, platform_reset_out_b_n_o}));
		host_bus_reset_n_i <= 1;
		for (int s = 0; s < 3; s++) begin
			for (int o = 0; o < 4; o++) begin
				wr(0, 16'h0001 | 16'(o) << 9);
				suspend_ram_in_n_i <= s == 0;
				soft_off_in_n_i <= s != 2;
				{kbd_cpu_reset_req_i, kbd_gate_low_req_i} <= 2'($urandom);
				cyc(3);
				chk("rails", 16'({s == 1 || (s == 2 && o[1]), {2{s == 2 && !o[0]}}, s != 0, s != 1,
					!kbd_cpu_reset_req_i, !kbd_gate_low_req_i}), 16'({memory_rail_switch_o, standby_rail_ctrl_0_n_o,
					standby_rail_ctrl_1_n_o, supply_on_ctrl_n_o, wake_event_n_o, keyboard_cpu_reset_n_o,
					address_line_20_gate_o}));
				rdchk(1, 16'h0003, 16'(s), "state");
			end
		end
		wr(0, 0);
		reset_button_in_n_i <= 0;
		cyc(2 + $urandom % (DEB - 6));
		reset_button_in_n_i <= 1;
		cyc(DEB + 4);
		chk("short press", 0, 16'(reset_button_o));
		reset_button_in_n_i <= 0;
		cyc(DEB + 4);
		chk("long press", 16'h0004, 16'({reset_button_o, platform_reset_out_a_n_o, platform_reset_out_b_n_o}));
		reset_button_in_n_i <= 1;
		cyc(DEB + 4);
		power_button_in_n_i <= 0;
		for (n = 0; power_request_pulse_n_o !== 1'b0 && n < 5; n++) cyc(1);
		for (n = 0; power_request_pulse_n_o === 1'b0 && n < 100; n++) cyc(1);
		chk("request pulse", REQ, 16'(n));
		power_button_in_n_i <= 1;
		sl_a <= 1;
		sl_b <= 1;
		cyc(6);
		chk("ack pair", 16'h0001, 16'({deep_sleep_ack_a_n_o, deep_sleep_ack_b_n_o}));
		wr(0, 16'h0100);
		cyc(4);
		chk("ack pair b", 0, 16'({deep_sleep_ack_a_n_o, deep_sleep_ack_b_n_o}));
		sl_a <= 0;
		sl_b <= 0;
		cyc(3);
		chk("ack off", 16'h0003, 16'({deep_sleep_ack_a_n_o, deep_sleep_ack_b_n_o}));
		case_intrusion_in_n_i <= 0;
		cyc(2);
		case_intrusion_in_n_i <= 1;
		cyc(2);
		rdchk(1, 16'h0040, 16'h0040, "case latch");
		wr(0, 16'h0002);
		rdchk(1, 16'h0040, 16'h0000, "case clear");
		// Standby LED on the fastest rate; the high phase must last one half period.
		wr(0, 16'h00B0);
		cyc(2);
		for (n = 0; standby_led_o === 1'b0 && n < 20; n++) cyc(1);
		for (n = 0; standby_led_o === 1'b1 && n < 20; n++) cyc(1);
		chk("led blink", 16'(pwrseq_pkg::LED_HALF_3 / 1000000), 16'(n));
		srst_i <= 1;
		power_good_style_strap_i <= 0;
		cyc(2);
		srst_i <= 0;
		cyc(2);
		rdchk(1, 16'h0020, 16'h0020, "strap");
		complete_run();
	end
endmodule
